// ---- placeholder_none.v ----
// Intentionally empty companion file
`timescale 1ns/100ps

// ---- rpp_defines.vh ----
// Offsets, field positions, reset values and timing counts for the mismatch protection block
`ifndef RPP_DEFINES_VH
`define RPP_DEFINES_VH

// Register offsets (byte addresses)
`define RPP_REG_SETPOINT   8'h00
`define RPP_REG_RATED      8'h04
`define RPP_REG_STATUS     8'h08
`define RPP_REG_STATE      8'h0c
`define RPP_REG_LIMIT      8'h10
`define RPP_REG_ACCUM      8'h14
`define RPP_REG_CUTLIM     8'h18
`define RPP_REG_FOLDLIM    8'h1c

// Status bit positions (sticky, write one to clear)
`define RPP_ST_FAST        0
`define RPP_ST_COMP        1
`define RPP_ST_OVER_CUR    2
`define RPP_ST_OVER_VOLT   3
`define RPP_ST_ARC         4
`define RPP_ST_RACK_ARC    5
`define RPP_ST_RACK_LOW    6
`define RPP_ST_W           7

// Reset values
`define RPP_RATED_RST      16'h2710

// Clock and time base
`define RPP_CLK_NS         4
`define RPP_MS_NS          1000000
`define RPP_TICK_CYC       (`RPP_MS_NS / `RPP_CLK_NS)
`define RPP_FAST_TRIP_NS   100
`define RPP_FAST_TRIP_CYC  (`RPP_FAST_TRIP_NS / `RPP_CLK_NS)

// Sequencer times in milliseconds
`define RPP_HOLD_MS        100
`define RPP_RECOVER_MS     30000
`define RPP_AVG_MS         5000

// Accumulator: one unit equals 60 s of decay at one count per ms
`define RPP_ACC_UNIT       60000
`define RPP_ACC_THR        120000
`define RPP_ACC_MAX        180000

// Fixed point fractions
`define RPP_PCT85_MUL      12'hd9a
`define RPP_PCT85_SH       12
`define RPP_PEAK16_MUL     13'h147b
`define RPP_PEAK16_SH      15
`define RPP_AVG_PCT        4
`define RPP_FLOOR_SH       2
`define RPP_RAMP_SH        4
`define RPP_RECOV_SH       6
`define RPP_FOLD_SH        6

`endif

// ---- rpp_load_model.sv ----
// Load model: reflected power returned for the power the stage is driving
`timescale 1ns/100ps
module rpp_load_model #(
  parameter W = 16
) (
  // Clock
  input  wire          mclk,
  // Drive side
  input  wire  [W-1:0] pwr_limit,
  input  wire          rf_drive_disable,
  // Mismatch, percent of forward power
  input  wire  [7:0]   refl_pct,
  // Reflected sample
  output logic [W-1:0] refl_pwr
);
  logic [W-1:0] refl_q;
  // No drive means nothing comes back, whatever the load
  always_ff @(posedge mclk)
    refl_q <= rf_drive_disable ? '0 : W'((32'(pwr_limit) * 32'(refl_pct)) / 32'h64);
  assign refl_pwr = refl_q;
endmodule // rpp_load_model

// ---- rpp_protect.v ----
// Reflected power protection: fast trip, computed trip, shutback/cutback and foldback
`timescale 1ns/100ps
`include "rpp_defines.vh"
// How it works
// [R1] Fast trip zeroes modulation drive and disables RF drive within 100 ns.
// [R2] Fast trip compares coupler sample to threshold and raises fast mismatch alarm.
// [R3] Computed peak trip limit is 16 percent of rated power.
// [R4] Computed peak over limit forces zero power and raises computed mismatch alarm.
// [R5] Computed, fast, over-current, over-voltage or arc alarms start a shutback.
// [R6] Shutback holds output power at zero for 100 ms.
// [R7] After the hold, power ramps exponentially toward the lower of set point and limit.
// [R8] Thirty seconds after a shutback, normal level loop control returns at full power.
// [R9] Each shutback adds one normalized unit to the cutback accumulator, which the code caps at ACC_MAX.
// [R10] Accumulator decays by one sixtieth per second, reaching zero after 60 s.
// [R11] Three shutbacks within 15 s push the accumulator over threshold: cutback.
// [R12] First cutback limits power to 85 percent of lower of set point, shutback power.
// [R13] Each further cutback scales the limit to 85 percent of its present level.
// [R14] Cutback limit never falls below 25 percent of full carrier power.
// [R15] Cutback recovery waits for accumulator zero, then restores power gradually.
// [R16] Reflected power is averaged over 5 s and compared to 4 percent of rated.
// [R17] While the average is over the limit, output power is lowered gradually.
// [R18] Rack arc and rack low supply requests also start a shutback.
// [R19] Threshold chosen so two shutbacks in 15 s never cut back, three always do.
// [R20] A shutback during ramp or recovery restarts the hold and adds accumulator.

module rpp_protect #(
  parameter        W          = 16,
  parameter [31:0] TICK_CYC   = `RPP_TICK_CYC,
  parameter [15:0] HOLD_MS    = `RPP_HOLD_MS,
  parameter [15:0] RECOVER_MS = `RPP_RECOVER_MS,
  parameter [12:0] AVG_MS     = `RPP_AVG_MS,
  parameter [17:0] ACC_UNIT   = `RPP_ACC_UNIT,
  parameter [17:0] ACC_THR    = `RPP_ACC_THR,
  parameter [17:0] ACC_MAX    = `RPP_ACC_MAX,
  parameter [15:0] RATED_RST  = `RPP_RATED_RST
) (
  // Clock and reset
  input  wire          mclk,
  input  wire          rst,
  // Register port
  input  wire [7:0]    reg_addr,
  input  wire [31:0]   reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output wire [31:0]   reg_rdata,
  // Measurements, same clock
  input  wire [W-1:0]  coupler_refl,
  input  wire [W-1:0]  calc_refl_peak,
  input  wire          calc_refl_valid,
  input  wire [W-1:0]  refl_pwr,
  // Alarm pins, asynchronous
  input  wire          over_cur_pin,
  input  wire          over_volt_pin,
  input  wire          arc_pin,
  input  wire          rack_arc_pin,
  input  wire          rack_low_supply_pin,
  // Drive controls and power limit
  output wire          mod_drive_zero,
  output wire          rf_drive_disable,
  output wire [W-1:0]  pwr_limit,
  output wire          fast_mismatch_trip_alarm,
  output wire          computed_mismatch_trip_alarm,
  output wire          cutback_active,
  output wire          foldback_active
);

  localparam [1:0] ST_NORM = 2'd0;
  localparam [1:0] ST_HOLD = 2'd1;
  localparam [1:0] ST_RAMP = 2'd2;
  localparam [12:0] AVG_MUL = (`RPP_AVG_PCT * AVG_MS) / 100;

  function [W-1:0] min2;
    input [W-1:0] a;
    input [W-1:0] b;
    begin
      min2 = (a < b) ? a : b;
    end
  endfunction

  function [W-1:0] pct85;
    input [W-1:0] x;
    reg   [W+11:0] p;
    begin
      p = x * `RPP_PCT85_MUL;
      pct85 = p[W+11:`RPP_PCT85_SH];
    end
  endfunction

  reg  [W-1:0]          setpoint_q;
  reg  [W-1:0]          rated_q;
  reg  [`RPP_ST_W-1:0]  status_q;
  reg  [31:0]           rdata_q;
  reg  [W-1:0]          peak_lim_q;
  reg  [4:0]            s1_q;
  reg  [4:0]            s2_q;
  reg  [4:0]            s3_q;
  reg  [4:0]            flt_q;
  reg  [4:0]            flt_prev_q;
  reg                   fast_prev_q;
  reg                   comp_prev_q;
  reg  [31:0]           tick_cnt_q;
  reg                   tick_q;
  reg  [1:0]            state_q;
  reg  [1:0]            state_d;
  reg  [15:0]           since_q;
  reg  [15:0]           since_d;
  reg  [W-1:0]          ramp_q;
  reg  [W-1:0]          ramp_d;
  reg  [W-1:0]          pwr_q;
  reg  [W-1:0]          pwr_d;
  reg                   zero_q;
  reg  [17:0]           acc_q;
  reg  [17:0]           acc_d;
  reg  [W-1:0]          cut_lim_q;
  reg  [W-1:0]          cut_lim_d;
  reg                   cut_act_q;
  reg                   cut_act_d;
  reg  [31:0]           avg_sum_q;
  reg  [12:0]           avg_cnt_q;
  reg                   fold_act_q;
  reg  [W-1:0]          fold_lim_q;

  wire [4:0]            pins = {rack_low_supply_pin, rack_arc_pin, arc_pin,
                                over_volt_pin, over_cur_pin};
  wire [4:0]            pin_rise = flt_q & ~flt_prev_q;
  wire                  fast_over = coupler_refl > peak_lim_q;
  wire                  comp_over = calc_refl_valid && (calc_refl_peak > peak_lim_q);
  wire                  fast_evt = fast_over & ~fast_prev_q;
  wire                  comp_evt = comp_over & ~comp_prev_q;
  // Any alarm edge restarts the sequence, even mid ramp or recovery
  wire                  sb = fast_evt | comp_evt | (|pin_rise); // see [R5] [R18] [R20]
  wire [W-1:0]          tgt = min2(setpoint_q, min2(cut_lim_q, fold_lim_q)); // see [R7]
  wire [W-1:0]          floor_lim = rated_q >> `RPP_FLOOR_SH;
  wire [W+12:0]         peak_prod = rated_q * `RPP_PEAK16_MUL;
  wire [W+12:0]         avg_lim = rated_q * AVG_MUL;
  wire [W:0]            ramp_up = {1'b0, ramp_q} + {1'b0, (tgt - ramp_q) >> `RPP_RAMP_SH} +
                                  {{W{1'b0}}, 1'b1};
  wire [17:0]           acc_dec = (tick_q && acc_q != 18'h0) ? acc_q - 18'h1 : acc_q;
  wire [18:0]           acc_sum = {1'b0, acc_dec} + {1'b0, ACC_UNIT};
  wire                  cut_evt = sb && (acc_sum > {1'b0, ACC_THR}); // see [R11] [R19]
  wire [W-1:0]          cut_base = cut_act_q ? cut_lim_q : min2(setpoint_q, pwr_q);
  wire [W-1:0]          cut_scaled = pct85(cut_base); // see [R12] [R13]
  wire [W:0]            cut_up = {1'b0, cut_lim_q} + {1'b0, rated_q >> `RPP_RECOV_SH} +
                                 {{W{1'b0}}, 1'b1};
  wire [W-1:0]          fold_step = (fold_lim_q >> `RPP_FOLD_SH) + {{(W-1){1'b0}}, 1'b1};
  wire [W:0]            fold_up = {1'b0, fold_lim_q} + {1'b0, fold_step};
  wire [31:0]           avg_next = avg_sum_q + {{(32-W){1'b0}}, refl_pwr};
  wire [`RPP_ST_W-1:0]  st_set = {pin_rise, comp_evt, fast_evt};
  wire [`RPP_ST_W-1:0]  st_clr = (reg_wr && reg_addr == `RPP_REG_STATUS) ?
                                 reg_wdata[`RPP_ST_W-1:0] : {`RPP_ST_W{1'b0}};

  assign reg_rdata                    = rdata_q;
  assign mod_drive_zero               = zero_q;
  assign rf_drive_disable             = zero_q;
  assign pwr_limit                    = pwr_q;
  assign fast_mismatch_trip_alarm     = status_q[`RPP_ST_FAST];
  assign computed_mismatch_trip_alarm = status_q[`RPP_ST_COMP];
  assign cutback_active               = cut_act_q;
  assign foldback_active              = fold_act_q;

  // Register port; set beats a clear that lands in the same cycle
  always @(posedge mclk)
  begin
    if (rst)
    begin
      setpoint_q <= RATED_RST;
      rated_q    <= RATED_RST;
      status_q   <= {`RPP_ST_W{1'b0}};
      rdata_q    <= 32'h0;
      peak_lim_q <= {W{1'b1}};
    end
    else
    begin
      if (reg_wr && reg_addr == `RPP_REG_SETPOINT)
        setpoint_q <= reg_wdata[W-1:0];
      if (reg_wr && reg_addr == `RPP_REG_RATED)
        rated_q <= reg_wdata[W-1:0];
      status_q   <= (status_q & ~st_clr) | st_set; // see [R2] [R4]
      peak_lim_q <= peak_prod[W+`RPP_PEAK16_SH-1:`RPP_PEAK16_SH]; // see [R3]
      rdata_q    <= 32'h0;
      if (reg_rd)
      begin
        case (reg_addr)
          `RPP_REG_SETPOINT: rdata_q <= {{(32-W){1'b0}}, setpoint_q};
          `RPP_REG_RATED:    rdata_q <= {{(32-W){1'b0}}, rated_q};
          `RPP_REG_STATUS:   rdata_q <= {{(32-`RPP_ST_W){1'b0}}, status_q};
          `RPP_REG_STATE:    rdata_q <= {28'h0, fold_act_q, cut_act_q, state_q};
          `RPP_REG_LIMIT:    rdata_q <= {{(32-W){1'b0}}, pwr_q};
          `RPP_REG_ACCUM:    rdata_q <= {14'h0, acc_q};
          `RPP_REG_CUTLIM:   rdata_q <= {{(32-W){1'b0}}, cut_lim_q};
          `RPP_REG_FOLDLIM:  rdata_q <= {{(32-W){1'b0}}, fold_lim_q};
          default:           rdata_q <= 32'h0;
        endcase
      end
    end
  end

  // Pins pass three flops; a level counts once stages two and three agree
  always @(posedge mclk)
  begin
    if (rst)
    begin
      s1_q        <= 5'h0;
      s2_q        <= 5'h0;
      s3_q        <= 5'h0;
      flt_q       <= 5'h0;
      flt_prev_q  <= 5'h0;
      fast_prev_q <= 1'b0;
      comp_prev_q <= 1'b0;
    end
    else
    begin
      s1_q        <= pins;
      s2_q        <= s1_q;
      s3_q        <= s2_q;
      flt_q       <= (flt_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
      flt_prev_q  <= flt_q;
      fast_prev_q <= fast_over;
      comp_prev_q <= comp_over;
    end
  end

  // One millisecond time base for all slow sequencing
  always @(posedge mclk)
  begin
    if (rst)
    begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end
    else if (tick_cnt_q >= TICK_CYC - 32'h1)
    begin
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q     <= 1'b0;
    end
  end

  // Shutback sequencer: hold at zero, exponential ramp, then normal loop
  always @*
  begin
    state_d = state_q;
    since_d = since_q;
    ramp_d  = (ramp_q > tgt) ? tgt : ramp_q;
    if (sb)
    begin
      state_d = ST_HOLD; // see [R6] [R20]
      since_d = 16'h0;
      ramp_d  = {W{1'b0}};
    end
    else
    begin
      case (state_q)
        ST_HOLD:
        begin
          ramp_d = {W{1'b0}};
          if (tick_q)
          begin
            since_d = since_q + 16'h1;
            if (since_d >= HOLD_MS)
              state_d = ST_RAMP; // see [R6]
          end
        end
        ST_RAMP:
        begin
          if (tick_q)
          begin
            since_d = since_q + 16'h1;
            // Plus one so the ramp always closes the last small gap
            if (ramp_q < tgt)
              ramp_d = (ramp_up[W-1:0] > tgt || ramp_up[W]) ? tgt : ramp_up[W-1:0]; // see [R7]
            if (since_d >= RECOVER_MS)
              state_d = ST_NORM; // see [R8]
          end
        end
        ST_NORM:
          ramp_d = tgt;
        default:
          state_d = ST_NORM;
      endcase
    end
    case (state_d)
      ST_HOLD: pwr_d = {W{1'b0}}; // see [R4] [R6]
      ST_RAMP: pwr_d = min2(ramp_d, tgt);
      default: pwr_d = tgt; // see [R8]
    endcase
  end

  // Outputs are taken from next state so a trip shows one edge after detection
  always @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= ST_NORM;
      since_q <= 16'h0;
      ramp_q  <= {W{1'b0}};
      pwr_q   <= {W{1'b0}};
      zero_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      since_q <= since_d;
      ramp_q  <= ramp_d;
      pwr_q   <= pwr_d;
      zero_q  <= (state_d == ST_HOLD); // see [R1]
    end
  end

  // Cutback accumulator and limit
  always @*
  begin
    acc_d     = acc_dec; // see [R10]
    cut_lim_d = cut_lim_q;
    cut_act_d = cut_act_q;
    if (sb)
      acc_d = (acc_sum > {1'b0, ACC_MAX}) ? ACC_MAX : acc_sum[17:0]; // see [R9] [R19]
    if (cut_evt)
    begin
      cut_act_d = 1'b1;
      cut_lim_d = (cut_scaled < floor_lim) ? floor_lim : cut_scaled; // see [R14]
    end
    else if (cut_act_q)
    begin
      // Recovery only begins once every remembered event has decayed away
      if (tick_q && acc_q == 18'h0)
      begin
        if (cut_up[W] || cut_up[W-1:0] >= rated_q)
        begin
          cut_lim_d = rated_q; // see [R15]
          cut_act_d = 1'b0;
        end
        else
          cut_lim_d = cut_up[W-1:0]; // see [R15]
      end
    end
    else
      cut_lim_d = rated_q;
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      acc_q     <= 18'h0;
      cut_lim_q <= RATED_RST;
      cut_act_q <= 1'b0;
    end
    else
    begin
      acc_q     <= acc_d;
      cut_lim_q <= cut_lim_d;
      cut_act_q <= cut_act_d;
    end
  end

  // Block average over the window; comparing sums avoids a divider
  always @(posedge mclk)
  begin
    if (rst)
    begin
      avg_sum_q  <= 32'h0;
      avg_cnt_q  <= 13'h0;
      fold_act_q <= 1'b0;
      fold_lim_q <= RATED_RST;
    end
    else if (tick_q)
    begin
      if (avg_cnt_q >= AVG_MS - 13'h1)
      begin
        avg_cnt_q  <= 13'h0;
        avg_sum_q  <= 32'h0;
        fold_act_q <= (avg_next > {{(19-W){1'b0}}, avg_lim}); // see [R16]
      end
      else
      begin
        avg_cnt_q <= avg_cnt_q + 13'h1;
        avg_sum_q <= avg_next;
      end
      if (fold_act_q)
        fold_lim_q <= (fold_lim_q > fold_step) ? fold_lim_q - fold_step : {W{1'b0}}; // see [R17]
      else if (fold_up[W] || fold_up[W-1:0] >= rated_q)
        fold_lim_q <= rated_q;
      else
        fold_lim_q <= fold_up[W-1:0];
    end
  end

endmodule // rpp_protect

// ---- rpp_protect_sva.sv ----
// Checker for the reflected power protection block
`timescale 1ns/100ps
module rpp_protect_chk #(
  parameter        W         = 16,
  parameter [31:0] TICK_CYC  = 250000,
  parameter [15:0] HOLD_MS   = 100,
  parameter [15:0] RATED_RST = 16'h2710
) (
  // Clock and reset
  input wire         mclk,
  input wire         rst,
  // Register port
  input wire [7:0]   reg_addr,
  input wire [31:0]  reg_wdata,
  input wire         reg_wr,
  input wire         reg_rd,
  input wire [31:0]  reg_rdata,
  // Measurements
  input wire [W-1:0] coupler_refl,
  input wire [W-1:0] calc_refl_peak,
  input wire         calc_refl_valid,
  // Drive controls and alarms
  input wire         mod_drive_zero,
  input wire         rf_drive_disable,
  input wire [W-1:0] pwr_limit,
  input wire         fast_mismatch_trip_alarm,
  input wire         computed_mismatch_trip_alarm,
  input wire         cutback_active,
  input wire         foldback_active
);
  localparam [31:0] LIM  = ({16'h0, RATED_RST} * 32'h147b) >> 15;
  localparam int    HMIN = (HOLD_MS - 2) * TICK_CYC;
  localparam int    HMAX = (HOLD_MS + 1) * TICK_CYC;
  logic [31:0] hold_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Length of the running zero hold
  always_ff @(posedge mclk)
    hold_q <= (rst || !mod_drive_zero) ? 32'h0 : hold_q + 32'h1;
  property p_fast;
    $rose(coupler_refl > LIM) |=> mod_drive_zero && pwr_limit == 0 && fast_mismatch_trip_alarm;
  endproperty
  a_fast: assert property (p_fast) else $error("fast trip late");
  property p_comp;
    $rose(calc_refl_valid && calc_refl_peak > LIM) |=>
      computed_mismatch_trip_alarm && mod_drive_zero && pwr_limit == 0;
  endproperty
  a_comp: assert property (p_comp) else $error("computed trip late");
  property p_twin;
    rf_drive_disable == mod_drive_zero;
  endproperty
  a_twin: assert property (p_twin) else $error("drive outputs differ");
  property p_zero;
    mod_drive_zero |-> pwr_limit == 0;
  endproperty
  a_zero: assert property (p_zero) else $error("power not zero in hold");
  property p_hold;
    $fell(mod_drive_zero) |-> hold_q >= HMIN && hold_q <= HMAX;
  endproperty
  a_hold: assert property (p_hold) else $error("hold length wrong");
  property p_ramp;
    !mod_drive_zero && !foldback_active && !$past(foldback_active) && !$past(foldback_active, 2)
      && !$past(reg_wr) && !$past(reg_wr, 2) |-> pwr_limit >= $past(pwr_limit);
  endproperty
  a_ramp: assert property (p_ramp) else $error("limit fell outside hold");
  property p_fold;
    foldback_active && !mod_drive_zero && !$past(reg_wr) && !$past(reg_wr, 2) |->
      17'(pwr_limit) + 17'($past(pwr_limit) >> 5) + 17'h2 >= 17'($past(pwr_limit));
  endproperty
  a_fold: assert property (p_fold) else $error("foldback step too big");
  property p_cut;
    $rose(cutback_active) |-> $rose(mod_drive_zero);
  endproperty
  a_cut: assert property (p_cut) else $error("cutback without shutback");
  property p_rdata;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
  property p_stick;
    $past(fast_mismatch_trip_alarm) && !($past(reg_wr) && $past(reg_addr) == 8'h08
      && $past(reg_wdata[0])) |-> fast_mismatch_trip_alarm;
  endproperty
  a_stick: assert property (p_stick) else $error("alarm dropped uncleared");
endmodule // rpp_protect_chk

bind rpp_protect rpp_protect_chk #(.W(W), .TICK_CYC(TICK_CYC), .HOLD_MS(HOLD_MS),
  .RATED_RST(RATED_RST)) chk_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .coupler_refl(coupler_refl), .calc_refl_peak(calc_refl_peak),
  .calc_refl_valid(calc_refl_valid), .mod_drive_zero(mod_drive_zero),
  .rf_drive_disable(rf_drive_disable), .pwr_limit(pwr_limit),
  .fast_mismatch_trip_alarm(fast_mismatch_trip_alarm),
  .computed_mismatch_trip_alarm(computed_mismatch_trip_alarm),
  .cutback_active(cutback_active), .foldback_active(foldback_active));

// ---- test_reflected_power_protection.sv ----
// Self-checking bench for the reflected power protection block
`timescale 1ns/100ps
`include "rpp_defines.vh"
module test_reflected_power_protection;
  localparam int TK  = 4;
  localparam int HLD = 100;
  localparam int WIN = 50;
  localparam int SP  = 8000;
  localparam int LIM = (`RPP_RATED_RST * `RPP_PEAK16_MUL) >> `RPP_PEAK16_SH;
  logic        mclk, rst, reg_wr, reg_rd, calc_refl_valid;
  logic [7:0]  reg_addr, refl_pct;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [15:0] coupler_refl, calc_refl_peak, refl_pwr, pwr_limit;
  logic [4:0]  pins;
  logic        mdz, rf_off, fast_al, comp_al, cutback_active, foldback_active;
  logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h18, 8'h1c, 8'hfc};
  int          n_mismatch, checked, cut, t;

  rpp_protect #(.TICK_CYC(TK), .HOLD_MS(HLD), .RECOVER_MS(120), .AVG_MS(WIN), .ACC_UNIT(600),
    .ACC_THR(1200), .ACC_MAX(1800)) rpp_protect_i (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .coupler_refl(coupler_refl), .calc_refl_peak(calc_refl_peak),
    .calc_refl_valid(calc_refl_valid), .refl_pwr(refl_pwr), .over_cur_pin(pins[0]),
    .over_volt_pin(pins[1]), .arc_pin(pins[2]), .rack_arc_pin(pins[3]),
    .rack_low_supply_pin(pins[4]), .mod_drive_zero(mdz), .rf_drive_disable(rf_off),
    .pwr_limit(pwr_limit), .fast_mismatch_trip_alarm(fast_al),
    .computed_mismatch_trip_alarm(comp_al), .cutback_active(cutback_active),
    .foldback_active(foldback_active));
  rpp_load_model rpp_load_model_i (.mclk(mclk), .pwr_limit(pwr_limit),
    .rf_drive_disable(rf_off), .refl_pct(refl_pct), .refl_pwr(refl_pwr));

  always #2 mclk = ~mclk;

  task automatic wrap_up();
    $display("Mismatches %0d, checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask

  // Waits on hold (0), cutback (1) or foldback (2)
  task automatic wsig(input int k, input logic v, input int n);
    int i;
    for (i = 0; i < n; i++)
    begin
      @(negedge mclk);
      if ((k == 0 ? mdz : k == 1 ? cutback_active : foldback_active) === v)
        break;
    end
    if (i == n)
    begin
      n_mismatch++;
      $display("ERROR at %0t: wait %h stuck at %h", $time, k, !v);
      wrap_up();
    end
  endtask

  function automatic int fcut(input int x);
    int y;
    y = (x * `RPP_PCT85_MUL) >> `RPP_PCT85_SH;
    return y > (`RPP_RATED_RST >> 2) ? y : (`RPP_RATED_RST >> 2);
  endfunction

  // Source 0 fast, 1 computed, 2..6 alarm pins
  task automatic sb(input int k);
    @(posedge mclk);
    if (k == 0)
      coupler_refl <= 16'(LIM + 1);
    else if (k == 1)
    begin
      calc_refl_peak  <= 16'(LIM + 1 + $urandom % 500);
      calc_refl_valid <= 1'b1;
    end
    else
      pins <= 5'h1 << (k - 2);
    wsig(0, 1'b1, k < 2 ? 25 : 12);
    chk(rf_off, 1'b1);
    chk(pwr_limit, 16'h0);
    chk(k == 0 ? fast_al : k == 1 ? comp_al : 1'b1, 1'b1);
    @(posedge mclk);
    coupler_refl    <= 16'($urandom % LIM);
    calc_refl_valid <= 1'b0;
    pins            <= 5'h0;
    rd(`RPP_REG_STATUS);
    chk(d[k], 1'b1);
    wr(`RPP_REG_STATUS, 32'h1 << k);
    rd(`RPP_REG_STATUS);
    chk(d[k], 1'b0);
    chk(fast_al | comp_al, 1'b0);
  endtask

  initial
  begin
    mclk = 0; rst = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
    coupler_refl = 0; calc_refl_peak = 0; calc_refl_valid = 0; pins = 0; refl_pct = 0;
    n_mismatch = 0;
    checked = 0;
    void'($urandom(10732));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      rd(ra[i]);
      chk(d, i < 4 ? 32'h2710 : 32'h0);
    end
    wr(`RPP_REG_SETPOINT, SP);
    wr(`RPP_REG_LIMIT, 32'h0);
    rd(`RPP_REG_LIMIT);
    chk(d, SP);
    // Exactly at the limit must not trip
    @(posedge mclk);
    coupler_refl    <= 16'(LIM);
    calc_refl_peak  <= 16'(LIM);
    calc_refl_valid <= 1'b1;
    repeat (8) @(negedge mclk);
    chk(mdz, 1'b0);
    for (int j = 0; j < 10; j++)
    begin
      sb(j % 7);
      if (j == 0)
      begin
        rd(`RPP_REG_ACCUM);
        chk(d > 32'h24e && d <= 32'h258, 1'b1);
      end
      cut = j < 2 ? SP : fcut(j == 2 ? SP : cut);
      chk(cutback_active, j > 1);
      rd(`RPP_REG_CUTLIM);
      chk(d, j > 1 ? cut : 32'h2710);
      wsig(0, 1'b0, (HLD + 2) * TK);
      chk(pwr_limit < cut, 1'b1);
      repeat (120) @(negedge mclk);
      chk(pwr_limit, cut);
    end
    for (t = 0; t < 5000 && d !== 32'h0; t++)
      rd(`RPP_REG_ACCUM);
    chk(t > 3000 && t < 5000, 1'b1);
    chk(cutback_active, 1'b1);
    wsig(1, 1'b0, 100 * TK);
    chk(pwr_limit, SP);
    // An average of exactly four percent is not over the limit
    @(posedge mclk);
    refl_pct <= 8'h5;
    repeat (3 * WIN * TK) @(negedge mclk);
    chk(foldback_active, 1'b0);
    @(posedge mclk);
    refl_pct <= 8'h6;
    wsig(2, 1'b1, 2 * WIN * TK + 20);
    repeat (30 * TK) @(negedge mclk);
    chk(pwr_limit < SP && pwr_limit > SP / 2, 1'b1);
    @(posedge mclk);
    refl_pct <= 8'h0;
    wsig(2, 1'b0, 3 * WIN * TK);
    wrap_up();
  end
endmodule // test_reflected_power_protection
